// ===== rtl/uhpf_pkg.sv
// Purpose: Shared constants and types for the pipe event flag block
// Assumes: 32-bit AXI4-Lite register bus, one pipe, one clock
// Notes:   Flags occupy bits 7:4 of the status word, lower bits read zero

package uhpf_pkg;

	// ----------------------------------------------------------------
	// Bus widths and responses
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SIZE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h10;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_LSB = 4;
	localparam int unsigned FLAG_W = 4;
	localparam int unsigned BIT_SHORT = 7;
	localparam int unsigned BIT_STALL = 6;
	localparam int unsigned BIT_OVERF = 5;
	localparam int unsigned BIT_NAK = 4;
	localparam int unsigned SIZE_W = 11;
	localparam logic [SIZE_W-1:0] SIZE_RST = 11'h040;
	localparam int unsigned CTRL_FREEZE = 0;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;

	typedef logic [DATA_W-1:0] uhpf_word_t;

	typedef enum {
		REG_STATUS,
		REG_CLEAR,
		REG_MASK,
		REG_SIZE,
		REG_CTRL,
		REG_NONE
	} uhpf_reg_t;

	// Order matches bits 7 down to 4
	typedef struct packed {
		logic short_pkt_flag;
		logic rx_stall_flag;
		logic pipe_overflow_flag;
		logic nak_received_flag;
	} uhpf_flags_t;

	typedef struct packed {
		logic pkt_done;
		logic [SIZE_W-1:0] pkt_len;
		logic stall;
		logic nak;
	} uhpf_evt_t;

endpackage

// ===== rtl/uhpf_pipe_flags.sv
// Purpose: Per-pipe event flags, mask, freeze and AXI4-Lite slave
// Assumes: Event strobes come from pipe logic on the same clock
// Notes:   Status is read-only, clear is write-one, reads of clear give 0
// Function
// - Short packet received sets short flag
// - Writing one to short clear clears it
// - Stall sets bit 6, masked interrupt
// - Stall freezes the pipe automatically
// - Writing one to stall clear clears it
// - Overflow sets bit 5, masked interrupt
// - Writing one to overflow clear clears it
// - NAK sets bit 4, masked interrupt
// - Writing one to NAK clear clears it
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.

module uhpf_pipe_flags
	import uhpf_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire uhpf_evt_t pipe_evt,
	output logic pipe_frozen,
	output logic irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic uhpf_reg_t decode(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_STATUS: decode = REG_STATUS;
			OFF_CLEAR: decode = REG_CLEAR;
			OFF_MASK: decode = REG_MASK;
			OFF_SIZE: decode = REG_SIZE;
			OFF_CTRL: decode = REG_CTRL;
			default: decode = REG_NONE;
		endcase
	endfunction

	function automatic uhpf_word_t strb_mask(input logic [STRB_W-1:0] s);
		uhpf_word_t m;
		m = WORD_ZERO;
		for (int i = 0; i < STRB_W; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		strb_mask = m;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic aw_full_q, w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	uhpf_word_t w_data_q;
	logic [STRB_W-1:0] w_strb_q;
	uhpf_flags_t flags_q;
	uhpf_flags_t flags_d;
	uhpf_flags_t pipe_irq_mask_reg_q;
	uhpf_flags_t mask_d;
	logic [SIZE_W-1:0] pipe_max_packet_size_q;
	uhpf_flags_t set_vec, clr_vec;
	logic aw_hs, w_hs, ar_hs, do_wr;
	logic bvalid_d, rvalid_d, aw_full_d, w_full_d;
	uhpf_reg_t wr_sel;
	uhpf_word_t wr_mask, wr_bits, status_word;
	logic freeze_d;

	// ----------------------------------------------------------------
	// Write channel handshakes
	// ----------------------------------------------------------------
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	// One write at a time: nothing new is taken until the response goes
	assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign aw_full_d = (aw_full_q | aw_hs) & ~do_wr;
	assign w_full_d = (w_full_q | w_hs) & ~do_wr;
	assign bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
	assign rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);

	assign wr_sel = decode(aw_addr_q);
	assign wr_mask = strb_mask(w_strb_q);
	assign wr_bits = w_data_q & wr_mask;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= OFF_STATUS;
			w_data_q <= WORD_ZERO;
			w_strb_q <= '0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			if (aw_hs) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_full_d & ~bvalid_d;
			s_axi_wready <= ~w_full_d & ~bvalid_d;
			s_axi_bvalid <= bvalid_d;
			if (do_wr) begin
				s_axi_bresp <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign status_word = uhpf_word_t'(flags_q) << FLAG_LSB;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= WORD_ZERO;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid <= rvalid_d;
			if (ar_hs) begin
				s_axi_rresp <= RESP_OKAY;
				case (decode(s_axi_araddr))
					REG_STATUS: s_axi_rdata <= status_word;
					REG_MASK: s_axi_rdata <=
						uhpf_word_t'(pipe_irq_mask_reg_q) << FLAG_LSB;
					REG_SIZE: s_axi_rdata <=
						uhpf_word_t'(pipe_max_packet_size_q);
					REG_CTRL: s_axi_rdata <=
						uhpf_word_t'(pipe_frozen) << CTRL_FREEZE;
					REG_CLEAR: s_axi_rdata <= WORD_ZERO;
					default: begin
						s_axi_rdata <= WORD_ZERO;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Events and flags
	// ----------------------------------------------------------------
	always_comb begin
		set_vec = uhpf_flags_t'(FLAGS_RST);
		set_vec.short_pkt_flag = pipe_evt.pkt_done &&
			(pipe_evt.pkt_len < pipe_max_packet_size_q);
		set_vec.rx_stall_flag = pipe_evt.stall;
		set_vec.pipe_overflow_flag = pipe_evt.pkt_done &&
			(pipe_evt.pkt_len > pipe_max_packet_size_q);
		set_vec.nak_received_flag = pipe_evt.nak;
	end

	// Only lanes written with a one clear; zero bits leave flags alone
	always_comb begin
		clr_vec = uhpf_flags_t'(FLAGS_RST);
		if (do_wr && wr_sel == REG_CLEAR) begin
			clr_vec = uhpf_flags_t'(wr_bits[FLAG_LSB +: FLAG_W]);
		end
	end

	// Set is ORed after the clear so a same-cycle event is never lost
	assign flags_d = uhpf_flags_t'(
		(flags_q & ~clr_vec) |
		set_vec);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flags_q <= uhpf_flags_t'(FLAGS_RST);
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------------------------------
	// Mask, packet size and freeze control
	// ----------------------------------------------------------------
	always_comb begin
		mask_d = pipe_irq_mask_reg_q;
		if (do_wr && wr_sel == REG_MASK) begin
			mask_d = uhpf_flags_t'(
				(pipe_irq_mask_reg_q & ~wr_mask[FLAG_LSB +: FLAG_W]) |
				wr_bits[FLAG_LSB +: FLAG_W]);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pipe_irq_mask_reg_q <= uhpf_flags_t'(FLAGS_RST);
		end else begin
			pipe_irq_mask_reg_q <= mask_d;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pipe_max_packet_size_q <= SIZE_RST;
		end else if (do_wr && wr_sel == REG_SIZE) begin
			pipe_max_packet_size_q <=
				(pipe_max_packet_size_q & ~wr_mask[SIZE_W-1:0]) |
				wr_bits[SIZE_W-1:0];
		end
	end

	// Software may unfreeze, but a stall in the same cycle keeps it frozen
	always_comb begin
		freeze_d = pipe_frozen;
		if (do_wr && wr_sel == REG_CTRL && wr_mask[CTRL_FREEZE]) begin
			freeze_d = w_data_q[CTRL_FREEZE];
		end
		if (pipe_evt.stall) begin
			freeze_d = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pipe_frozen <= 1'b0;
		end else begin
			pipe_frozen <= freeze_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	// Built from next values so irq moves in the same cycle as the flags
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_d & mask_d);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	logic clr_wr;
	assign clr_wr = do_wr && wr_sel == REG_CLEAR;

	property p_short_set;
		pipe_evt.pkt_done && pipe_evt.pkt_len < pipe_max_packet_size_q
			|=> flags_q.short_pkt_flag;
	endproperty
	a_short_set: assert property (p_short_set)
		else $error("short packet flag not set");

	property p_short_clr;
		clr_wr && wr_bits[BIT_SHORT] && !set_vec.short_pkt_flag
			|=> !flags_q.short_pkt_flag;
	endproperty
	a_short_clr: assert property (p_short_clr)
		else $error("short packet flag not cleared");

	property p_stall_irq;
		pipe_evt.stall && mask_d.rx_stall_flag
			|=> status_word[BIT_STALL] && irq;
	endproperty
	a_stall_irq: assert property (p_stall_irq)
		else $error("stall did not raise flag and irq");

	property p_freeze;
		pipe_evt.stall |=> pipe_frozen ##1 (pipe_frozen ||
			$past(do_wr && wr_sel == REG_CTRL));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("pipe not frozen after stall");

	property p_stall_clr;
		clr_wr && wr_bits[BIT_STALL] && !pipe_evt.stall
			|=> !flags_q.rx_stall_flag;
	endproperty
	a_stall_clr: assert property (p_stall_clr)
		else $error("stall flag not cleared");

	property p_ovf_irq;
		pipe_evt.pkt_done && pipe_evt.pkt_len > pipe_max_packet_size_q &&
			mask_d.pipe_overflow_flag |=> status_word[BIT_OVERF] && irq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq)
		else $error("overflow did not raise flag and irq");

	property p_ovf_clr;
		clr_wr && wr_bits[BIT_OVERF] && !set_vec.pipe_overflow_flag
			|=> !flags_q.pipe_overflow_flag;
	endproperty
	a_ovf_clr: assert property (p_ovf_clr)
		else $error("overflow flag not cleared");

	property p_nak_irq;
		pipe_evt.nak && mask_d.nak_received_flag
			|=> status_word[BIT_NAK] && irq;
	endproperty
	a_nak_irq: assert property (p_nak_irq)
		else $error("nak did not raise flag and irq");

	property p_nak_clr;
		clr_wr && wr_bits[BIT_NAK] && !pipe_evt.nak
			|=> !flags_q.nak_received_flag;
	endproperty
	a_nak_clr: assert property (p_nak_clr)
		else $error("nak flag not cleared");

	property p_zero_keeps;
		clr_wr && flags_q.nak_received_flag && !wr_bits[BIT_NAK]
			|=> flags_q.nak_received_flag;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("zero clear bit changed a flag");

	property p_set_wins;
		clr_wr && wr_bits[BIT_STALL] && pipe_evt.stall
			|=> flags_q.rx_stall_flag;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear beat a same-cycle event");

	property p_irq_level;
		##1 irq == |(flags_q & pipe_irq_mask_reg_q);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("irq does not follow masked flags");

	property p_bvalid_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped early");

	c_stall_irq: cover property (pipe_evt.stall ##1 irq);
	c_clear: cover property (clr_wr ##1 s_axi_bvalid);
	c_short: cover property (set_vec.short_pkt_flag ##[1:4] ar_hs);
	c_set_wins: cover property (clr_wr && wr_bits[BIT_NAK] && pipe_evt.nak);

endmodule

// ===== verification/uhpf_usb_dev.sv
// Purpose: Far-side pipe event source standing in for a USB device
// Assumes: Events arrive on the system clock as one-cycle strobes
// Notes:   Length is scrambled outside pkt_done so it cannot be trusted

module uhpf_usb_dev
	import uhpf_pkg::*;
(
	input wire logic clock,
	output uhpf_evt_t evt
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		evt = '0;
	end

	// ------------------------------------------------------------
	// One event strobe, launched at the next rising edge
	// ------------------------------------------------------------
	task automatic pulse(input logic d, input logic [SIZE_W-1:0] len,
		input logic st, input logic nk);
		@(posedge clock);
		evt <= '{pkt_done: d, pkt_len: len, stall: st, nak: nk};
		@(posedge clock);
		// Stale length would hide a design that ignores pkt_done
		evt <= '{pkt_done: 1'b0, pkt_len: ~len, stall: 1'b0, nak: 1'b0};
	endtask
endmodule

// ===== verification/usb_host_pipe_event_flags_bench.sv
// Purpose: Register-level checks of the pipe event flag block
// Assumes: AXI4-Lite master tasks, events from the far-side model
// Notes:   Expected values come from the register map alone

module usb_host_pipe_event_flags_bench
	import uhpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, frozen, irq;
	uhpf_word_t wdata = '0, rdata;
	logic [STRB_W-1:0] wstrb = '0;
	logic [1:0] bresp, rresp, r;
	uhpf_word_t d, e;
	uhpf_evt_t evt;
	int bad_count = 0;
	int tests_run = 0;

	always #10 clock = ~clock;

	uhpf_usb_dev dev (.clock(clock), .evt(evt));

	uhpf_pipe_flags uut (.clock(clock), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pipe_evt(evt),
		.pipe_frozen(frozen), .irq(irq));

	// ------------------------------------------------------------
	// Bus tasks and comparisons
	// ------------------------------------------------------------
	task automatic chk(input uhpf_word_t g, input uhpf_word_t x);
		tests_run++;
		if (g !== x) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input uhpf_word_t v,
		output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clock);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
			if (n > 50) begin
				chk(32'h0000_0001, 32'h0000_0000);
				rs = 2'h3;
				break;
			end
		end
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output uhpf_word_t v,
		output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clock);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				v = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
			if (n > 50) begin
				chk(32'h0000_0001, 32'h0000_0000);
				v = '0;
				rs = 2'h3;
				break;
			end
		end
	endtask

	task automatic wc(input logic [ADDR_W-1:0] a, input uhpf_word_t v);
		wr(a, v, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task automatic rc(input logic [ADDR_W-1:0] a, input uhpf_word_t x);
		rd(a, d, r);
		chk(d, x);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task automatic pins(input logic f, input logic i);
		// Look mid-cycle so the edge that launched the pins has settled
		@(negedge clock);
		chk({30'h0, frozen, irq}, {30'h0, f, i});
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		rc(OFF_STATUS, WORD_ZERO);
		rc(OFF_MASK, WORD_ZERO);
		rc(OFF_SIZE, 32'h0000_0040);
		rc(OFF_CTRL, WORD_ZERO);
		pins(1'b0, 1'b0);
		wr(8'h20, 32'hffff_ffff, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(8'h20, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		wc(OFF_MASK, 32'h0000_00f0);
		dev.pulse(1'b1, 11'h03f, 1'b0, 1'b0);
		rc(OFF_STATUS, 32'h0000_0080);
		pins(1'b0, 1'b1);
		// Exactly the maximum size is neither short nor overflow
		dev.pulse(1'b1, 11'h040, 1'b0, 1'b0);
		rc(OFF_STATUS, 32'h0000_0080);
		dev.pulse(1'b1, 11'h041, 1'b0, 1'b0);
		rc(OFF_STATUS, 32'h0000_00a0);
		dev.pulse(1'b0, 11'h001, 1'b0, 1'b1);
		rc(OFF_STATUS, 32'h0000_00b0);
		pins(1'b0, 1'b1);
		dev.pulse(1'b0, 11'h001, 1'b1, 1'b0);
		rc(OFF_STATUS, 32'h0000_00f0);
		pins(1'b1, 1'b1);
		wc(OFF_CLEAR, WORD_ZERO);
		wc(OFF_STATUS, WORD_ZERO);
		rc(OFF_STATUS, 32'h0000_00f0);
		e = 32'h0000_00f0;
		for (int i = 7; i >= 4; i--) begin
			wc(OFF_CLEAR, 32'h0000_0001 << i);
			e[i] = 1'b0;
			rc(OFF_STATUS, e);
		end
		pins(1'b1, 1'b0);
		wc(OFF_CTRL, WORD_ZERO);
		pins(1'b0, 1'b0);
		// Only the overflow enable is on: a NAK must stay quiet
		wc(OFF_MASK, 32'h0000_0020);
		dev.pulse(1'b0, 11'h002, 1'b0, 1'b1);
		pins(1'b0, 1'b0);
		dev.pulse(1'b1, 11'h7ff, 1'b0, 1'b0);
		pins(1'b0, 1'b1);
		wc(OFF_MASK, 32'h0000_0040);
		pins(1'b0, 1'b0);
		dev.pulse(1'b0, 11'h002, 1'b1, 1'b0);
		pins(1'b1, 1'b1);
		wc(OFF_CLEAR, 32'h0000_00f0);
		rc(OFF_STATUS, WORD_ZERO);
		// New NAK and STALL land on the edge where their clear executes
		fork
			wc(OFF_CLEAR, 32'h0000_0050);
			begin
				@(posedge clock);
				dev.pulse(1'b0, 11'h003, 1'b1, 1'b1);
			end
		join
		rc(OFF_STATUS, 32'h0000_0050);
		// Limits follow a reprogrammed maximum packet size
		wc(OFF_SIZE, 32'h0000_0008);
		rc(OFF_SIZE, 32'h0000_0008);
		dev.pulse(1'b1, 11'h020, 1'b0, 1'b0);
		rc(OFF_STATUS, 32'h0000_0070);
		dev.pulse(1'b1, 11'h007, 1'b0, 1'b0);
		rc(OFF_STATUS, 32'h0000_00f0);
		wc(OFF_CTRL, WORD_ZERO);
		pins(1'b0, 1'b1);
		wc(OFF_CTRL, 32'h0000_0001);
		rc(OFF_CTRL, 32'h0000_0001);
		pins(1'b1, 1'b1);
		end_sim;
	end

	initial begin
		#200000;
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		end_sim;
	end
endmodule
